// [pkg/icg_pkg.sv]
package icg_pkg;
   // clock rate of the controller
   localparam int unsigned CLK_MHZ = 200;
   // processor start delay after a wake event, in ns
   localparam int unsigned CPU_START_NS = 500;
   localparam int unsigned CPU_START_CYC = (CPU_START_NS * CLK_MHZ + 999) / 1000;
   // internal oscillator settle interval, in ns
   localparam int unsigned SETTLE_NS = 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   // primary oscillator start-up and pll lock, in cycles of clk (parameters of top)
   localparam int unsigned OST_CYC_DEF = 8192;
   localparam int unsigned PLL_LOCK_CYC_DEF = 8192;
   localparam int unsigned CNT_W = 16;
   // oscillator control field positions
   localparam int unsigned SCS_LSB = 0;
   localparam int unsigned IRCF_LSB = 4;
   localparam logic [2:0] IRCF_RST = 3'h3;
   // internal frequency codes at or above this value use the high-frequency source
   localparam logic [2:0] IRCF_HF_MIN = 3'h3;
   // configuration oscillator codes
   localparam logic [3:0] FOSC_CRYSTAL_MAX = 4'h5;
   localparam logic [3:0] FOSC_PLL = 4'h6;
   localparam logic [1:0] SCS_PRIMARY = 2'h0;
   localparam logic [1:0] SCS_SECONDARY = 2'h1;
   // interrupt vectors
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;
   localparam int unsigned PCG_REGS = 3;
   localparam int unsigned PCG_BITS = 8;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_IDLE = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE = 4'h8
   } icg_state_t;
endpackage

// [rtl/icg_gate.sv]
`timescale 1ns/1ps
`default_nettype none
// one peripheral: clock-off gates clock and registers, enable gates function
module icg_gate (
   input wire logic clk,
   input wire logic srst,
   input wire logic periph_clk_en,
   input wire logic module_enable_bit,
   input wire logic module_clock_off_bit,
   input wire logic wr_req,
   input wire logic rd_req,
   output logic clk_on,
   output logic func_on,
   output logic wr_ok,
   output logic rd_valid
);
   logic next_clk_on;
   logic next_func_on;
   logic next_wr_ok;
   logic next_rd_valid;

   always_comb begin
      next_clk_on = periph_clk_en & ~module_clock_off_bit;
      next_func_on = next_clk_on & module_enable_bit;
      next_wr_ok = wr_req & ~module_clock_off_bit;
      next_rd_valid = rd_req & ~module_clock_off_bit;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clk_on <= 1'b0;
         func_on <= 1'b0;
         wr_ok <= 1'b0;
         rd_valid <= 1'b0;
      end else begin
         clk_on <= next_clk_on;
         func_on <= next_func_on;
         wr_ok <= next_wr_ok;
         rd_valid <= next_rd_valid;
      end
   end

   a_gate_blocks_wr: assert property (@(posedge clk) disable iff (srst)
      module_clock_off_bit |=> !wr_ok) else $error("write passed gated module");
endmodule
`default_nettype wire

// [rtl/icg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module icg_top #(
   parameter int unsigned OST_CYC = icg_pkg::OST_CYC_DEF,
   parameter int unsigned PLL_LOCK_CYC = icg_pkg::PLL_LOCK_CYC_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sleep_exec,
   input wire logic wake_event,
   input wire logic wake_is_irq,
   input wire logic irq_high_prio,
   input wire logic idle_on_sleep_enable,
   input wire logic [1:0] sys_clk_select_field,
   input wire logic [2:0] internal_freq_select,
   input wire logic low_freq_source_select,
   input wire logic [3:0] osc_config_select,
   input wire logic global_int_enable_high,
   input wire logic global_int_enable_low,
   input wire logic watchdog_enable,
   input wire logic failsafe_enable,
   input wire logic secondary_osc_ok,
   input wire logic [20:0] pc_current,
   input wire logic [4:0] stack_pointer_in,
   input wire logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] peripheral_clock_gate,
   input wire logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] module_enable_bit,
   input wire logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_wr_req,
   input wire logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_rd_req,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic primary_osc_en,
   output logic internal_osc_en,
   output logic primary_osc_timer_done,
   output logic high_freq_internal_stable,
   output logic mid_freq_internal_stable,
   output logic secondary_osc_running,
   output logic internal_osc_idle,
   output logic vector_load,
   output logic [20:0] vector_addr,
   output logic stack_push,
   output logic [20:0] top_of_stack,
   output logic [4:0] stack_pointer_out,
   output logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_clk_on,
   output logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_func_on,
   output logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_wr_ok,
   output logic [icg_pkg::PCG_REGS*icg_pkg::PCG_BITS-1:0] periph_rd_valid
);
   localparam int unsigned NMOD = icg_pkg::PCG_REGS * icg_pkg::PCG_BITS;
   localparam logic [icg_pkg::CNT_W-1:0] CSD_N = icg_pkg::CNT_W'(icg_pkg::CPU_START_CYC);
   localparam logic [icg_pkg::CNT_W-1:0] SET_N = icg_pkg::CNT_W'(icg_pkg::SETTLE_CYC);

   // ****************************************
   // source selection
   // ****************************************
   logic on_internal;
   logic on_secondary;
   logic crystal;
   logic pll_mode;
   logic int_req;
   logic hf_sel;
   always_comb begin
      // lower select bit is deliberately not looked at here
      on_internal = sys_clk_select_field[1];
      on_secondary = sys_clk_select_field == icg_pkg::SCS_SECONDARY;
      pll_mode = osc_config_select == icg_pkg::FOSC_PLL;
      // pll mode still runs a crystal, so it needs the start-up timer as well
      crystal = osc_config_select <= icg_pkg::FOSC_CRYSTAL_MAX || pll_mode;
      int_req = (internal_freq_select != 3'h0) | low_freq_source_select;
      hf_sel = internal_freq_select >= icg_pkg::IRCF_HF_MIN;
   end

   // ****************************************
   // power state machine
   // ****************************************
   icg_pkg::icg_state_t state;
   icg_pkg::icg_state_t next_state;
   logic [icg_pkg::CNT_W-1:0] csd_cnt;
   logic [icg_pkg::CNT_W-1:0] next_csd_cnt;
   logic [icg_pkg::CNT_W-1:0] ost_cnt;
   logic [icg_pkg::CNT_W-1:0] next_ost_cnt;
   logic from_sleep;
   logic next_from_sleep;
   logic next_cpu_clk_en;
   logic next_periph_clk_en;
   logic next_primary_osc_en;
   logic next_internal_osc_idle;
   logic next_ost_done;
   logic ost_busy;

   always_comb begin
      next_state = state;
      next_csd_cnt = csd_cnt;
      next_ost_cnt = ost_cnt;
      next_from_sleep = from_sleep;
      next_ost_done = primary_osc_timer_done;
      next_primary_osc_en = primary_osc_en;
      ost_busy = ost_cnt != '0;
      unique case (state)
         icg_pkg::ST_RUN: begin
            if (sleep_exec) begin
               next_state = idle_on_sleep_enable ? icg_pkg::ST_IDLE : icg_pkg::ST_SLEEP;
               next_from_sleep = !idle_on_sleep_enable;
            end
         end
         icg_pkg::ST_IDLE, icg_pkg::ST_SLEEP: begin
            if (wake_event) begin
               next_state = icg_pkg::ST_WAKE;
               next_csd_cnt = CSD_N;
               if (from_sleep && !on_internal && !on_secondary && crystal) begin
                  // start-up timer runs beside the processor start delay
                  next_ost_cnt = pll_mode ? icg_pkg::CNT_W'(OST_CYC + PLL_LOCK_CYC)
                                          : icg_pkg::CNT_W'(OST_CYC);
                  next_ost_done = 1'b0;
               end
            end
         end
         icg_pkg::ST_WAKE: begin
            if (csd_cnt != '0) begin
               next_csd_cnt = csd_cnt - 1'b1;
            end
            if (ost_busy) begin
               next_ost_cnt = ost_cnt - 1'b1;
               next_ost_done = ost_cnt == icg_pkg::CNT_W'(1);
            end
            // idle enable and select inputs are never written back
            if (csd_cnt <= icg_pkg::CNT_W'(1) && ost_cnt <= icg_pkg::CNT_W'(1)) begin
               next_state = icg_pkg::ST_RUN;
            end
         end
         default: next_state = icg_pkg::ST_RUN;
      endcase
      // primary stops in sleep and whenever running from the internal mux
      next_primary_osc_en = !on_internal && !on_secondary &&
                            next_state != icg_pkg::ST_SLEEP;
      if (on_internal) begin
         next_ost_done = 1'b0;
      end else if (!crystal && !ost_busy && next_primary_osc_en) begin
         next_ost_done = 1'b1;
      end
      next_cpu_clk_en = next_state == icg_pkg::ST_RUN;
      next_periph_clk_en = next_state != icg_pkg::ST_SLEEP;
      next_internal_osc_idle = next_state == icg_pkg::ST_IDLE && on_internal;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= icg_pkg::ST_RUN;
         csd_cnt <= '0;
         ost_cnt <= '0;
         from_sleep <= 1'b0;
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         primary_osc_en <= 1'b1;
         primary_osc_timer_done <= 1'b0;
         internal_osc_idle <= 1'b0;
      end else begin
         state <= next_state;
         csd_cnt <= next_csd_cnt;
         ost_cnt <= next_ost_cnt;
         from_sleep <= next_from_sleep;
         cpu_clk_en <= next_cpu_clk_en;
         periph_clk_en <= next_periph_clk_en;
         primary_osc_en <= next_primary_osc_en;
         primary_osc_timer_done <= next_ost_done;
         internal_osc_idle <= next_internal_osc_idle;
      end
   end

   // ****************************************
   // internal oscillator and stable flags
   // ****************************************
   logic [icg_pkg::CNT_W-1:0] set_cnt;
   logic [icg_pkg::CNT_W-1:0] next_set_cnt;
   logic stable;
   logic next_stable;
   logic next_int_en;
   logic next_hf_st;
   logic next_mf_st;
   logic next_secondary_oscillator_run;
   logic int_needed;

   always_comb begin
      int_needed = on_internal && next_state != icg_pkg::ST_SLEEP;
      // watchdog and fail-safe monitor keep it alive even with selects clear
      next_int_en = (int_req && int_needed) || watchdog_enable || failsafe_enable;
      next_set_cnt = set_cnt;
      next_stable = stable;
      if (!next_int_en) begin
         next_stable = 1'b0;
         next_set_cnt = '0;
      end else if (!internal_osc_en) begin
         next_set_cnt = SET_N;
         next_stable = 1'b0;
      end else if (set_cnt != '0) begin
         next_set_cnt = set_cnt - 1'b1;
         next_stable = set_cnt == icg_pkg::CNT_W'(1);
      end
      // a stable flag clears on sleep entry unless the watchdog or fail-safe monitor keeps the oscillator on
      next_hf_st = next_stable && int_req && hf_sel;
      next_mf_st = next_stable && int_req && !hf_sel && internal_freq_select != 3'h0;
      next_secondary_oscillator_run = on_secondary && secondary_osc_ok;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         set_cnt <= '0;
         stable <= 1'b0;
         internal_osc_en <= 1'b0;
         high_freq_internal_stable <= 1'b0;
         mid_freq_internal_stable <= 1'b0;
         secondary_osc_running <= 1'b0;
      end else begin
         set_cnt <= next_set_cnt;
         stable <= next_stable;
         internal_osc_en <= next_int_en;
         high_freq_internal_stable <= next_hf_st;
         mid_freq_internal_stable <= next_mf_st;
         secondary_osc_running <= next_secondary_oscillator_run;
      end
   end

   // ****************************************
   // interrupt wake: vector and stack
   // ****************************************
   logic next_vec_load;
   logic [20:0] next_vec_addr;
   logic [20:0] next_tos;
   logic [4:0] next_sp;
   logic irq_wake;

   always_comb begin
      irq_wake = wake_event && wake_is_irq &&
                 (state == icg_pkg::ST_IDLE || state == icg_pkg::ST_SLEEP) &&
                 (global_int_enable_high || global_int_enable_low);
      next_vec_load = irq_wake;
      next_vec_addr = vector_addr;
      next_tos = top_of_stack;
      next_sp = stack_pointer_out;
      if (irq_wake) begin
         next_vec_addr = irq_high_prio ? icg_pkg::VEC_HIGH : icg_pkg::VEC_LOW;
         next_tos = pc_current;
         next_sp = stack_pointer_in + 5'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         vector_load <= 1'b0;
         stack_push <= 1'b0;
         vector_addr <= '0;
         top_of_stack <= '0;
         stack_pointer_out <= '0;
      end else begin
         vector_load <= next_vec_load;
         stack_push <= next_vec_load;
         vector_addr <= next_vec_addr;
         top_of_stack <= next_tos;
         stack_pointer_out <= next_sp;
      end
   end

   // ****************************************
   // peripheral module gating
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NMOD; gi++) begin : g_mod
         icg_gate icg_gate_i (
            .clk(clk),
            .srst(srst),
            .periph_clk_en(next_periph_clk_en),
            .module_enable_bit(module_enable_bit[gi]),
            .module_clock_off_bit(peripheral_clock_gate[gi]),
            .wr_req(periph_wr_req[gi]),
            .rd_req(periph_rd_req[gi]),
            .clk_on(periph_clk_on[gi]),
            .func_on(periph_func_on[gi]),
            .wr_ok(periph_wr_ok[gi]),
            .rd_valid(periph_rd_valid[gi])
         );
      end
   endgenerate

   // ****************************************
   // checks
   // ****************************************
   sequence s_idle_wake;
      state == icg_pkg::ST_IDLE && wake_event;
   endsequence

   a_idle_cpu_off: assert property (@(posedge clk) disable iff (srst)
      state == icg_pkg::ST_IDLE |-> !cpu_clk_en && periph_clk_en) else $error("idle clocks wrong");
   a_sleep_idle_entry: assert property (@(posedge clk) disable iff (srst)
      state == icg_pkg::ST_RUN && sleep_exec && idle_on_sleep_enable |=>
      state == icg_pkg::ST_IDLE) else $error("idle not entered");
   a_wake_start_delay: assert property (@(posedge clk) disable iff (srst)
      s_idle_wake |=> !cpu_clk_en [*1] ##[0:300] cpu_clk_en) else $error("start delay wrong");
   a_primary_shutdown: assert property (@(posedge clk) disable iff (srst)
      on_internal |=> !primary_osc_en && !primary_osc_timer_done) else $error("primary on");
   a_flags_clear: assert property (@(posedge clk) disable iff (srst)
      !int_req |=> !high_freq_internal_stable && !mid_freq_internal_stable) else $error("flag set");
   a_flag_after_settle: assert property (@(posedge clk) disable iff (srst)
      $rose(internal_osc_en) |-> !high_freq_internal_stable [*2]) else $error("flag early");
   a_wdt_keeps_osc: assert property (@(posedge clk) disable iff (srst)
      watchdog_enable || failsafe_enable |=> internal_osc_en) else $error("osc stopped");
   a_vector_load: assert property (@(posedge clk) disable iff (srst)
      irq_wake |=> vector_load && stack_push &&
      vector_addr == ($past(irq_high_prio) ? icg_pkg::VEC_HIGH : icg_pkg::VEC_LOW))
      else $error("vector");
endmodule
`default_nettype wire

// [verification/icg_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module icg_top_test;
   localparam int unsigned NMOD = icg_pkg::PCG_REGS * icg_pkg::PCG_BITS;
   localparam int unsigned CPU_WAIT = icg_pkg::CPU_START_CYC;
   localparam int unsigned SETTLE = icg_pkg::SETTLE_CYC;
   logic clk, srst, sleep_exec, wake_event, wake_is_irq, irq_high_prio;
   logic idle_on_sleep_enable, low_freq_source_select, watchdog_enable, failsafe_enable;
   logic global_int_enable_high, global_int_enable_low, secondary_osc_ok;
   logic [1:0] sys_clk_select_field;
   logic [2:0] internal_freq_select;
   logic [3:0] osc_config_select;
   logic [20:0] pc_current, vector_addr, top_of_stack;
   logic [4:0] stack_pointer_in, stack_pointer_out;
   logic [NMOD-1:0] peripheral_clock_gate, module_enable_bit, periph_wr_req, periph_rd_req;
   logic [NMOD-1:0] periph_clk_on, periph_func_on, periph_wr_ok, periph_rd_valid;
   logic cpu_clk_en, periph_clk_en, primary_osc_en, internal_osc_en, primary_osc_timer_done;
   logic high_freq_internal_stable, mid_freq_internal_stable, secondary_osc_running;
   logic internal_osc_idle, vector_load, stack_push;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [NMOD-1:0] gate_tab [3] = '{24'ha50f3c, 24'h000000, 24'hffffff};
   logic [NMOD-1:0] en_tab [3] = '{24'h0ff099, 24'h5a5a5a, 24'hffffff};

   // short oscillator counts keep the crystal wake inside the run budget
   icg_top #(.OST_CYC(20), .PLL_LOCK_CYC(10)) icg_top_i (
      .clk(clk), .srst(srst), .sleep_exec(sleep_exec), .wake_event(wake_event),
      .wake_is_irq(wake_is_irq), .irq_high_prio(irq_high_prio),
      .idle_on_sleep_enable(idle_on_sleep_enable), .sys_clk_select_field(sys_clk_select_field),
      .internal_freq_select(internal_freq_select), .low_freq_source_select(low_freq_source_select),
      .osc_config_select(osc_config_select), .global_int_enable_high(global_int_enable_high),
      .global_int_enable_low(global_int_enable_low), .watchdog_enable(watchdog_enable),
      .failsafe_enable(failsafe_enable), .secondary_osc_ok(secondary_osc_ok),
      .pc_current(pc_current), .stack_pointer_in(stack_pointer_in),
      .peripheral_clock_gate(peripheral_clock_gate), .module_enable_bit(module_enable_bit),
      .periph_wr_req(periph_wr_req), .periph_rd_req(periph_rd_req), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .primary_osc_en(primary_osc_en),
      .internal_osc_en(internal_osc_en), .primary_osc_timer_done(primary_osc_timer_done),
      .high_freq_internal_stable(high_freq_internal_stable),
      .mid_freq_internal_stable(mid_freq_internal_stable),
      .secondary_osc_running(secondary_osc_running), .internal_osc_idle(internal_osc_idle),
      .vector_load(vector_load), .vector_addr(vector_addr), .stack_push(stack_push),
      .top_of_stack(top_of_stack), .stack_pointer_out(stack_pointer_out),
      .periph_clk_on(periph_clk_on), .periph_func_on(periph_func_on),
      .periph_wr_ok(periph_wr_ok), .periph_rd_valid(periph_rd_valid)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // *****************************************
   // checking helpers
   // *****************************************
   task automatic stop_test;
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return cpu_clk_en;
         1: return internal_osc_en;
         2: return high_freq_internal_stable;
         3: return mid_freq_internal_stable;
         4: return vector_load;
         5: return primary_osc_timer_done;
         default: return secondary_osc_running;
      endcase
   endfunction

   // polls once a cycle, so a one-cycle pulse is not missed
   task automatic waitf(input int sel, input logic val, input int max);
      int n;
      n = 0;
      while (sig(sel) !== val && n < max) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(sig(sel), val);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_sleep;
      @(posedge clk);
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
   endtask

   task automatic pulse_wake(input logic irq, input logic [20:0] pc, input logic [4:0] sp);
      @(posedge clk);
      wake_event <= 1'b1;
      wake_is_irq <= irq;
      pc_current <= pc;
      stack_pointer_in <= sp;
      @(posedge clk);
      wake_event <= 1'b0;
      wake_is_irq <= 1'b0;
      // step off the edge so the one-cycle vector pulse is read after it lands
      #1;
   endtask

   // idle on the internal mux, then an interrupt wake; checks vector, stack, delay
   task automatic idle_wake(input logic hi, input logic [20:0] pc, input logic [4:0] sp);
      pulse_sleep();
      waitf(0, 1'b0, 3);
      chk({internal_osc_idle, periph_clk_en}, 2'b11);
      idle(20);
      pulse_wake(1'b1, pc, sp);
      waitf(4, 1'b1, 3);
      chk(vector_addr, hi ? 21'h000008 : 21'h000018);
      chk({stack_push, top_of_stack, stack_pointer_out}, {1'b1, pc, sp + 5'h01});
      idle(CPU_WAIT - 40);
      chk({cpu_clk_en, periph_clk_en, internal_osc_en}, 3'b011);
      waitf(0, 1'b1, 60);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles > 20000) begin
         fail_count++;
         stop_test();
      end
   end

   // *****************************************
   // main sequence
   // *****************************************
   initial begin
      srst = 1'b1;
      {sleep_exec, wake_event, wake_is_irq, irq_high_prio, idle_on_sleep_enable} = '0;
      {low_freq_source_select, watchdog_enable, failsafe_enable, secondary_osc_ok} = '0;
      {global_int_enable_high, global_int_enable_low} = '0;
      sys_clk_select_field = 2'h0;
      internal_freq_select = icg_pkg::IRCF_RST;
      osc_config_select = 4'h6;
      pc_current = '0;
      stack_pointer_in = '0;
      peripheral_clock_gate = '0;
      module_enable_bit = '0;
      periph_wr_req = '0;
      periph_rd_req = '0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      idle(1);
      chk({cpu_clk_en, periph_clk_en, primary_osc_en, internal_osc_idle}, 4'he);
      // module gating in run mode, every pattern with all read requests active and writes on ungated or enabled modules
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         peripheral_clock_gate <= gate_tab[i];
         module_enable_bit <= en_tab[i];
         periph_wr_req <= ~gate_tab[i] | en_tab[i];
         periph_rd_req <= '1;
         idle(3);
         chk(periph_clk_on, {~gate_tab[i]});
         chk(periph_func_on, {en_tab[i] & ~gate_tab[i]});
         chk(periph_wr_ok, {(~gate_tab[i] | en_tab[i]) & ~gate_tab[i]});
         chk(periph_rd_valid, {~gate_tab[i]});
      end
      // switch onto the internal mux with the lower select bit set
      // frequency field left at its reset code
      @(posedge clk);
      idle_on_sleep_enable <= 1'b1;
      global_int_enable_high <= 1'b1;
      irq_high_prio <= 1'b1;
      @(posedge clk);
      sys_clk_select_field <= 2'h3;
      waitf(1, 1'b1, 4);
      chk({primary_osc_en, primary_osc_timer_done}, 2'b00);
      idle(SETTLE - 20);
      chk({high_freq_internal_stable, cpu_clk_en}, 2'b01);
      waitf(2, 1'b1, 30);
      idle_wake(1'b1, 21'h01234, 5'h07);
      chk({high_freq_internal_stable, primary_osc_en, cpu_clk_en}, 3'b101);
      @(posedge clk);
      global_int_enable_high <= 1'b0;
      global_int_enable_low <= 1'b1;
      irq_high_prio <= 1'b0;
      internal_freq_select <= 3'h2;
      waitf(3, 1'b1, SETTLE + 10);
      idle_wake(1'b0, 21'h1fffe, 5'h1e);
      // all selects clear: oscillator off unless the watchdog or monitor needs it
      @(posedge clk);
      internal_freq_select <= 3'h0;
      waitf(1, 1'b0, 4);
      chk({high_freq_internal_stable, mid_freq_internal_stable}, 2'b00);
      @(posedge clk);
      watchdog_enable <= 1'b1;
      waitf(1, 1'b1, 4);
      @(posedge clk);
      watchdog_enable <= 1'b0;
      failsafe_enable <= 1'b1;
      idle(3);
      chk(internal_osc_en, 1'b1);
      @(posedge clk);
      failsafe_enable <= 1'b0;
      low_freq_source_select <= 1'b1;
      idle(3);
      chk(internal_osc_en, 1'b1);
      idle(SETTLE);
      chk({high_freq_internal_stable, mid_freq_internal_stable}, 2'b00);
      // secondary idle reports through the running bit
      @(posedge clk);
      low_freq_source_select <= 1'b0;
      sys_clk_select_field <= 2'h1;
      secondary_osc_ok <= 1'b1;
      pulse_sleep();
      waitf(6, 1'b1, 4);
      pulse_wake(1'b0, 21'h0, 5'h0);
      waitf(0, 1'b1, CPU_WAIT + 10);
      // crystal with pll: full sleep, then the start-up timers on wake
      @(posedge clk);
      idle_on_sleep_enable <= 1'b0;
      sys_clk_select_field <= 2'h0;
      idle(40);
      pulse_sleep();
      waitf(0, 1'b0, 3);
      chk(periph_clk_en, 1'b0);
      idle(10);
      pulse_wake(1'b0, 21'h0, 5'h0);
      idle(1);
      chk(primary_osc_timer_done, 1'b0);
      // past the bare start-up count: the pll lock time must still be pending
      idle(22);
      chk(primary_osc_timer_done, 1'b0);
      waitf(5, 1'b1, 40);
      waitf(0, 1'b1, CPU_WAIT + 10);
      stop_test();
   end
endmodule
`default_nettype wire
